// File: dbg_pkg.sv
// constants shared by the breakpoint and debug unit
// assumes byte-wide registers, one per aligned wishbone word
package dbg_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CUR_PC_LOW   = 16'ha098;
  localparam logic [15:0] IDX_CUR_PC_HIGH  = 16'ha099;
  localparam logic [15:0] IDX_CUR_PC_TOP   = 16'ha09a;
  localparam logic [15:0] IDX_NEXT_PC_LOW  = 16'ha09b;
  localparam logic [15:0] IDX_NEXT_PC_HIGH = 16'ha09c;
  localparam logic [15:0] IDX_NEXT_PC_TOP  = 16'ha09d;
  localparam logic [15:0] IDX_STEP_KEY     = 16'ha09e;
  localparam logic [15:0] IDX_DBG_SLV_ADDR = 16'ha09f;
  localparam logic [15:0] IDX_INT_FLAG     = 16'ha0e0;
  localparam logic [15:0] IDX_INT_ENABLE   = 16'ha0e1;
  localparam logic [15:0] IDX_INT_CONTROL  = 16'ha0e2;
  localparam logic [15:0] IDX_SUSPEND      = 16'ha0e3;
  localparam logic [15:0] IDX_BP1_LOW      = 16'ha0f0;
  localparam logic [15:0] IDX_BP1_HIGH     = 16'ha0f1;
  localparam logic [15:0] IDX_BP1_TOP      = 16'ha0f2;
  localparam logic [15:0] IDX_BP2_LOW      = 16'ha0f4;
  localparam logic [15:0] IDX_BP2_HIGH     = 16'ha0f5;
  localparam logic [15:0] IDX_BP2_TOP      = 16'ha0f6;
  // field positions
  localparam int BIT_STEP       = 7;
  localparam int BIT_BP2        = 1;
  localparam int BIT_BP1        = 0;
  localparam int BIT_IRQ_PERMIT = 7;
  localparam int BIT_WDT_PERMIT = 6;
  localparam int BIT_T2_PERMIT  = 5;
  localparam int BIT_T1_PERMIT  = 4;
  localparam int BIT_T0_PERMIT  = 3;
  localparam int BIT_ACTIVE     = 0;
  localparam int BIT_PORT_EN    = 7;
  // masks of implemented bits
  localparam logic [7:0] INT_BITS_MASK  = 8'h83;
  localparam logic [7:0] SUSP_BITS_MASK = 8'hf9;
  localparam logic [7:0] PERMIT_MASK    = 8'hf8;
  // values after reset
  localparam logic [7:0] RST_INT_FLAG   = 8'h00;
  localparam logic [7:0] RST_INT_EN     = 8'h00;
  localparam logic [7:0] RST_SUSPEND    = 8'hf8;
  localparam logic [7:0] RST_STEP_KEY   = 8'h00;
  localparam logic [7:0] RST_DBG_ID     = 8'h36;
  localparam logic [23:0] RST_PC        = 24'h000000;
  // key and vectors
  localparam logic [7:0] STEP_KEY_VALUE = 8'h96;
  localparam logic [7:0] VEC_DEBUG      = 8'h83;
  localparam logic [7:0] VEC_BREAKPOINT = 8'h7b;
  localparam logic [7:0] VEC_NONE       = 8'h00;
endpackage : dbg_pkg

// File: bp_cmp_if.sv
// carrier between the register core and the pc comparator
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface bp_cmp_if;
  logic [1:0][23:0] bp_addr;
  logic             step_en;
  logic [1:0]       hit;
  logic             step_hit;
  logic [23:0]      cur_pc;
  logic [23:0]      next_pc;
  modport core (output bp_addr, output step_en, input hit, input step_hit, input cur_pc, input next_pc);
  modport cmp  (input bp_addr, input step_en, output hit, output step_hit, output cur_pc, output next_pc);
endinterface : bp_cmp_if

// File: bp_compare.sv
// pc comparator: matches fetches against two breakpoints
// assumes fetch signals are synchronous to clk_i
`timescale 1ns/10ps
module bp_compare
  import dbg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        fetch_valid_i,
  input  wire logic [23:0] fetch_pc_i,
  input  wire logic [23:0] exec_pc_i,
  input  wire logic        fetch_in_isr_i,
  bp_cmp_if.cmp            bus
);
  typedef struct packed {
    logic [1:0]  hit;
    logic        step_hit;
    logic [23:0] cur_pc;
    logic [23:0] next_pc;
  } cmp_s;

  cmp_s st_r;
  cmp_s st_nxt;
  logic [1:0] match;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bp
      // RULE21: compare every fetch
      assign match[g] = fetch_valid_i && (fetch_pc_i == bus.bp_addr[g]);
    end
  endgenerate

  always_comb begin
    st_nxt          = st_r;
    st_nxt.hit      = match;
    // RULE19: step on isr fetch
    st_nxt.step_hit = fetch_valid_i && fetch_in_isr_i && bus.step_en;
    st_nxt.cur_pc   = exec_pc_i;
    st_nxt.next_pc  = fetch_pc_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{hit: 2'h0, step_hit: 1'b0, cur_pc: RST_PC, next_pc: RST_PC};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.hit      = st_r.hit;
  assign bus.step_hit = st_r.step_hit;
  assign bus.cur_pc   = st_r.cur_pc;
  assign bus.next_pc  = st_r.next_pc;
endmodule : bp_compare

// File: bp_debug_unit.sv
// breakpoint and debug controller with wishbone register slave
// assumes cpu and second i2c slave signals are on clk_i
// Summary of operation
// RULE1: step interrupt requested only while step enable bit 7 is set
// RULE2: enable bits 1 and 0 gate breakpoint 2 and 1 interrupts
// RULE3: routine entry clears permit bits, stopping interrupts, watchdog, timers
// RULE4: bit 7 lets interrupts except watchdog preempt; cleared at entry
// RULE5: bit 6 lets watchdog count during the routine
// RULE6: bits 5..3 gate timer 2..0 counting only, not their interrupts
// RULE7: routine status bit 0 set by hardware on routine entry
// RULE8: software clears routine status bit before leaving the routine
// RULE9: software sets permit bits again before leaving the routine
// RULE10: software changes suspension register only inside debug routine
// RULE11: each breakpoint compares 24 bits built from low, high, top bytes
// RULE12: on a hit the just executed pc is captured read-only
// RULE13: on a hit the next pc is captured read-only
// RULE14: single step enabled only while key register holds 0x96
// RULE15: port enabled and second slave address equal to id gives debug interrupt
// RULE16: debug id register resets to 0x36
// RULE17: debug interrupt has top priority, vector 0x83
// RULE18: breakpoint match issues breakpoint interrupt, vector 0x7b
// RULE19: step flag set on fetch from interrupt routine, held until cleared
// RULE20: breakpoint flags set on pc match, held until cleared
// RULE21: flags set regardless of enable; interrupt needs the enable
// RULE22: all permit bits set after reset
`timescale 1ns/10ps
module bp_debug_unit
  import dbg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [17:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // cpu fetch side
  input  wire logic        fetch_valid_i,
  input  wire logic [23:0] fetch_pc_i,
  input  wire logic [23:0] exec_pc_i,
  input  wire logic        fetch_in_isr_i,
  // routine entry
  input  wire logic        isr_enter_i,
  input  wire logic        isr_is_debug_i,
  // second i2c slave
  input  wire logic        i2c2_addr_valid_i,
  input  wire logic [6:0]  i2c2_addr_i,
  // interrupt requests
  output logic             brk_irq_o,
  output logic             dbg_irq_o,
  output logic      [7:0]  irq_vector_o,
  // suspension outputs
  output logic             irq_permit_o,
  output logic             wdt_count_en_o,
  output logic      [2:0]  timer_count_en_o,
  output logic             routine_active_o
);
  typedef struct packed {
    // software registers
    logic [7:0]  int_flag;
    logic [7:0]  int_en;
    logic [7:0]  susp;
    logic [7:0]  step_key;
    logic [7:0]  dbg_id;
    // breakpoint compare values
    logic [23:0] bp1;
    logic [23:0] bp2;
    // captured pcs
    logic [23:0] cur_pc;
    logic [23:0] next_pc;
    // debug request and bus answer
    logic        dbg_pend;
    logic        ack;
    logic [7:0]  rdata;
    // interrupt outputs
    logic        brk_irq;
    logic        dbg_irq;
    logic [7:0]  vector;
  } core_s;

  core_s r_r;
  core_s r_nxt;

  bp_cmp_if cmp_bus ();

  bp_compare u_cmp (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .fetch_valid_i  (fetch_valid_i),
    .fetch_pc_i     (fetch_pc_i),
    .exec_pc_i      (exec_pc_i),
    .fetch_in_isr_i (fetch_in_isr_i),
    .bus            (cmp_bus)
  );

  // RULE11: 24-bit compare values
  assign cmp_bus.bp_addr[0] = r_r.bp1;
  assign cmp_bus.bp_addr[1] = r_r.bp2;
  // RULE14: key unlocks single step
  assign cmp_bus.step_en    = (r_r.step_key == STEP_KEY_VALUE);

  // bus decode
  logic        req;
  logic        wr;
  logic [15:0] idx;
  logic [7:0]  wd;
  logic [7:0]  rd;
  // event and request terms
  logic [7:0]  ev;
  logic        any_ev;
  logic        dbg_match;
  logic        brk_req;

  assign req = cyc_i && stb_i;
  assign idx = adr_i[17:2];
  assign wd  = dat_i[7:0];
  // write lands at the edge where the master sees ack
  assign wr  = req && we_i && r_r.ack && sel_i[0];

  always_comb begin
    rd = 8'h00;
    case (idx)
      IDX_CUR_PC_LOW: begin
        rd = r_r.cur_pc[7:0];
      end
      IDX_CUR_PC_HIGH: begin
        rd = r_r.cur_pc[15:8];
      end
      IDX_CUR_PC_TOP: begin
        rd = r_r.cur_pc[23:16];
      end
      IDX_NEXT_PC_LOW: begin
        rd = r_r.next_pc[7:0];
      end
      IDX_NEXT_PC_HIGH: begin
        rd = r_r.next_pc[15:8];
      end
      IDX_NEXT_PC_TOP: begin
        rd = r_r.next_pc[23:16];
      end
      IDX_STEP_KEY: begin
        rd = r_r.step_key;
      end
      IDX_DBG_SLV_ADDR: begin
        rd = r_r.dbg_id;
      end
      IDX_INT_FLAG: begin
        rd = r_r.int_flag;
      end
      IDX_INT_ENABLE: begin
        rd = r_r.int_en;
      end
      IDX_INT_CONTROL: begin
        rd = 8'h00;
      end
      IDX_SUSPEND: begin
        rd = r_r.susp;
      end
      IDX_BP1_LOW: begin
        rd = r_r.bp1[7:0];
      end
      IDX_BP1_HIGH: begin
        rd = r_r.bp1[15:8];
      end
      IDX_BP1_TOP: begin
        rd = r_r.bp1[23:16];
      end
      IDX_BP2_LOW: begin
        rd = r_r.bp2[7:0];
      end
      IDX_BP2_HIGH: begin
        rd = r_r.bp2[15:8];
      end
      IDX_BP2_TOP: begin
        rd = r_r.bp2[23:16];
      end
      default: begin
        rd = 8'h00;
      end
    endcase
  end

  always_comb begin
    r_nxt = r_r;
    // bus handshake: one-cycle ack per request
    if (req && !r_r.ack) begin
      r_nxt.ack   = 1'b1;
      r_nxt.rdata = rd;
    end else begin
      r_nxt.ack   = 1'b0;
      r_nxt.rdata = 8'h00;
    end

    // register writes
    if (wr) begin
      case (idx)
        IDX_STEP_KEY: begin
          r_nxt.step_key = wd;
        end
        IDX_DBG_SLV_ADDR: begin
          r_nxt.dbg_id = wd;
        end
        IDX_INT_ENABLE: begin
          r_nxt.int_en = wd & INT_BITS_MASK;
        end
        IDX_SUSPEND: begin
          r_nxt.susp = wd & SUSP_BITS_MASK;
        end
        IDX_BP1_LOW: begin
          r_nxt.bp1[7:0] = wd;
        end
        IDX_BP1_HIGH: begin
          r_nxt.bp1[15:8] = wd;
        end
        IDX_BP1_TOP: begin
          r_nxt.bp1[23:16] = wd;
        end
        IDX_BP2_LOW: begin
          r_nxt.bp2[7:0] = wd;
        end
        IDX_BP2_HIGH: begin
          r_nxt.bp2[15:8] = wd;
        end
        IDX_BP2_TOP: begin
          r_nxt.bp2[23:16] = wd;
        end
        IDX_INT_FLAG: begin
          r_nxt.int_flag = wd & INT_BITS_MASK;
        end
        // captured pcs are read-only
        IDX_CUR_PC_LOW: begin
          r_nxt.cur_pc = r_r.cur_pc;
        end
        IDX_CUR_PC_HIGH: begin
          r_nxt.cur_pc = r_r.cur_pc;
        end
        IDX_CUR_PC_TOP: begin
          r_nxt.cur_pc = r_r.cur_pc;
        end
        IDX_NEXT_PC_LOW: begin
          r_nxt.next_pc = r_r.next_pc;
        end
        IDX_NEXT_PC_HIGH: begin
          r_nxt.next_pc = r_r.next_pc;
        end
        IDX_NEXT_PC_TOP: begin
          r_nxt.next_pc = r_r.next_pc;
        end
        default: begin
          r_nxt.int_flag = r_r.int_flag;
        end
      endcase
    end

    // RULE20: sticky match flags, set wins
    ev               = 8'h00;
    ev[BIT_BP1]      = cmp_bus.hit[0];
    ev[BIT_BP2]      = cmp_bus.hit[1];
    // RULE19: sticky step flag
    ev[BIT_STEP]     = cmp_bus.step_hit;
    // RULE21: flags ignore enables
    r_nxt.int_flag   = r_nxt.int_flag | ev;
    any_ev           = |ev;

    // RULE12: capture executed pc
    if (any_ev) begin
      r_nxt.cur_pc  = cmp_bus.cur_pc;
      // RULE13: capture next pc
      r_nxt.next_pc = cmp_bus.next_pc;
    end

    // RULE15: debug address match
    dbg_match = i2c2_addr_valid_i
             && r_r.dbg_id[BIT_PORT_EN]
             && (i2c2_addr_i == r_r.dbg_id[6:0]);
    if (isr_enter_i && isr_is_debug_i) begin
      r_nxt.dbg_pend = 1'b0;
    end
    if (dbg_match) begin
      r_nxt.dbg_pend = 1'b1;
    end

    // RULE3: entry clears permits
    if (isr_enter_i) begin
      // RULE4: irq permit cleared too
      r_nxt.susp             = r_nxt.susp & ~PERMIT_MASK;
      // RULE7: mark routine active
      r_nxt.susp[BIT_ACTIVE] = 1'b1;
    end

    // RULE1: step gated by enable
    // RULE2: per breakpoint enables
    brk_req = |(r_nxt.int_flag & r_nxt.int_en);
    // RULE18: breakpoint interrupt request
    r_nxt.brk_irq = brk_req;
    r_nxt.dbg_irq = r_nxt.dbg_pend;
    // RULE17: debug vector has priority
    if (r_nxt.dbg_pend) begin
      r_nxt.vector = VEC_DEBUG;
    end else if (brk_req) begin
      r_nxt.vector = VEC_BREAKPOINT;
    end else begin
      r_nxt.vector = VEC_NONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_r.int_flag <= RST_INT_FLAG;
      r_r.int_en   <= RST_INT_EN;
      // RULE22: permits set at reset
      r_r.susp     <= RST_SUSPEND;
      r_r.step_key <= RST_STEP_KEY;
      // RULE16: default debug id
      r_r.dbg_id   <= RST_DBG_ID;
      r_r.bp1      <= RST_PC;
      r_r.bp2      <= RST_PC;
      r_r.cur_pc   <= RST_PC;
      r_r.next_pc  <= RST_PC;
      r_r.dbg_pend <= 1'b0;
      r_r.ack      <= 1'b0;
      r_r.rdata    <= 8'h00;
      r_r.brk_irq  <= 1'b0;
      r_r.dbg_irq  <= 1'b0;
      r_r.vector   <= VEC_NONE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign dat_o            = {24'h000000, r_r.rdata};
  assign ack_o            = r_r.ack;
  assign brk_irq_o        = r_r.brk_irq;
  assign dbg_irq_o        = r_r.dbg_irq;
  assign irq_vector_o     = r_r.vector;
  // RULE4: preemption permit out
  assign irq_permit_o     = r_r.susp[BIT_IRQ_PERMIT];
  // RULE5: watchdog counting permit
  assign wdt_count_en_o   = r_r.susp[BIT_WDT_PERMIT];
  // RULE6: timer counting permits only
  assign timer_count_en_o = {r_r.susp[BIT_T2_PERMIT], r_r.susp[BIT_T1_PERMIT], r_r.susp[BIT_T0_PERMIT]};
  assign routine_active_o = r_r.susp[BIT_ACTIVE];
endmodule : bp_debug_unit

// File: bp_debug_unit_chk.sv
// checker: wishbone timing, vectors, suspension on routine entry
// assumes binding to bp_debug_unit, one clock, sync reset
`timescale 1ns/10ps
module bp_debug_unit_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       we_i,
  input wire logic       ack_o,
  input wire logic       isr_enter_i,
  input wire logic       isr_is_debug_i,
  input wire logic       brk_irq_o,
  input wire logic       dbg_irq_o,
  input wire logic [7:0] irq_vector_o,
  input wire logic       irq_permit_o,
  input wire logic       wdt_count_en_o,
  input wire logic [2:0] timer_count_en_o,
  input wire logic       routine_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_taken;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_held;
    !irq_permit_o && !wdt_count_en_o && timer_count_en_o == 3'b000 && routine_active_o;
  endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  a_ack_answer: assert property (s_taken |=> ack_o)
    else $error("request not answered");
  a_entry_suspend: assert property (isr_enter_i |-> ##[1:2] s_held)
    else $error("routine entry did not suspend");
  a_vec_debug: assert property (dbg_irq_o |-> irq_vector_o == 8'h83)
    else $error("debug vector wrong");
  a_vec_break: assert property (brk_irq_o && !dbg_irq_o |-> irq_vector_o == 8'h7b)
    else $error("breakpoint vector wrong");
  a_vec_idle: assert property (!brk_irq_o && !dbg_irq_o |-> irq_vector_o == 8'h00)
    else $error("vector without request");
  a_debug_held: assert property ($fell(dbg_irq_o) |->
    $past(isr_enter_i && isr_is_debug_i) || $past(isr_enter_i && isr_is_debug_i, 2))
    else $error("debug request dropped");
  a_break_held: assert property ($fell(brk_irq_o) |->
    $past(cyc_i && stb_i && we_i) || $past(cyc_i && stb_i && we_i, 2))
    else $error("breakpoint request dropped");
endmodule : bp_debug_unit_chk

bind bp_debug_unit bp_debug_unit_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o),
  .isr_enter_i(isr_enter_i), .isr_is_debug_i(isr_is_debug_i), .brk_irq_o(brk_irq_o),
  .dbg_irq_o(dbg_irq_o), .irq_vector_o(irq_vector_o), .irq_permit_o(irq_permit_o),
  .wdt_count_en_o(wdt_count_en_o), .timer_count_en_o(timer_count_en_o), .routine_active_o(routine_active_o)
);

// File: cpu_dbg_host.sv
// model of cpu fetch side and second i2c slave address source
// assumes clk_i is the unit clock; drives just after rising edges
`timescale 1ns/10ps
module cpu_dbg_host (
  input  wire logic        clk_i,
  output logic             fetch_valid_o,
  output logic      [23:0] fetch_pc_o,
  output logic      [23:0] exec_pc_o,
  output logic             fetch_in_isr_o,
  output logic             isr_enter_o,
  output logic             isr_is_debug_o,
  output logic             i2c_valid_o,
  output logic      [6:0]  i2c_addr_o
);
  initial begin
    {fetch_valid_o, fetch_in_isr_o, isr_enter_o, isr_is_debug_o, i2c_valid_o} = '0;
    {fetch_pc_o, exec_pc_o, i2c_addr_o} = '0;
  end
  // released buses show the inverse of the last value
  task fetch(input logic [23:0] p, input logic [23:0] e, input logic s);
    @(posedge clk_i);
    {fetch_valid_o, fetch_in_isr_o, fetch_pc_o, exec_pc_o} <= {1'b1, s, p, e};
    @(posedge clk_i);
    {fetch_valid_o, fetch_pc_o, exec_pc_o} <= {1'b0, ~p, ~e};
  endtask : fetch
  task enter(input logic d);
    @(posedge clk_i);
    {isr_enter_o, isr_is_debug_o} <= {1'b1, d};
    @(posedge clk_i);
    {isr_enter_o, isr_is_debug_o} <= {1'b0, ~d};
  endtask : enter
  task i2c(input logic [6:0] a);
    @(posedge clk_i);
    {i2c_valid_o, i2c_addr_o} <= {1'b1, a};
    @(posedge clk_i);
    {i2c_valid_o, i2c_addr_o} <= {1'b0, ~a};
  endtask : i2c
endmodule : cpu_dbg_host

// File: bp_debug_unit_tb.sv
// self-checking bench for the breakpoint and debug unit
// assumes dbg_pkg, cpu_dbg_host and the bound checker
`timescale 1ns/10ps
module bp_debug_unit_tb;
  import dbg_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, fv, fisr, ien, idbg, iv, brk, dbg, irqp, wdte, act;
  logic [17:0] adr;
  logic [31:0] wdat, rdat;
  logic [23:0] fpc, epc, p1, p2, e1;
  logic [7:0]  vec, q, kv, d;
  logic [6:0]  ia, a;
  logic [2:0]  tmr;
  logic [3:0]  sel, sel_v;
  int          bad_count, total_checks;
  bp_debug_unit dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .fetch_valid_i(fv), .fetch_pc_i(fpc), .exec_pc_i(epc),
    .fetch_in_isr_i(fisr), .isr_enter_i(ien), .isr_is_debug_i(idbg), .i2c2_addr_valid_i(iv),
    .i2c2_addr_i(ia), .brk_irq_o(brk), .dbg_irq_o(dbg), .irq_vector_o(vec), .irq_permit_o(irqp),
    .wdt_count_en_o(wdte), .timer_count_en_o(tmr), .routine_active_o(act)
  );
  cpu_dbg_host host (
    .clk_i(clk_i), .fetch_valid_o(fv), .fetch_pc_o(fpc), .exec_pc_o(epc), .fetch_in_isr_o(fisr),
    .isr_enter_o(ien), .isr_is_debug_o(idbg), .i2c_valid_o(iv), .i2c_addr_o(ia)
  );
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  function logic [7:0] f_vec(input logic g, input logic b);
    return g ? VEC_DEBUG : (b ? VEC_BREAKPOINT : VEC_NONE);
  endfunction : f_vec
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  task chkb(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask : chkb
  task wb(input logic w, input logic [15:0] i, input logic [7:0] v);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, sel_v, i, 2'b00, 24'h0, v};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      bad_count++;
      summarize;
    end
    q = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask : wb
  task wr(input logic [15:0] i, input logic [7:0] v);
    wb(1'b1, i, v);
  endtask : wr
  task rd(input logic [15:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk8(q, e);
  endtask : rd
  task idle;
    repeat (3) @(posedge clk_i);
  endtask : idle
  initial begin
    {rst_i, cyc, stb, we, adr, wdat, bad_count, total_checks} = {1'b1, 53'h0, 64'h0};
    {sel, sel_v} = 8'h11;
    void'($urandom(32'h1d6a));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_DBG_SLV_ADDR, RST_DBG_ID);
    rd(IDX_SUSPEND, 8'hf8);
    chkb(wdte & irqp & (&tmr), 1'b1);
    wr(IDX_INT_CONTROL, 8'hff);
    rd(IDX_INT_CONTROL, 8'h00);
    wr(16'ha0a0, 8'h55);
    rd(16'ha0a0, 8'h00);
    p1 = 24'($urandom);
    p2 = p1 ^ 24'h800001;
    e1 = 24'($urandom);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_BP1_LOW + 16'(k), p1[8*k+:8]);
      wr(IDX_BP2_LOW + 16'(k), p2[8*k+:8]);
    end
    for (int k = 0; k < 3; k++) begin
      rd(IDX_BP1_LOW + 16'(k), p1[8*k+:8]);
      rd(IDX_BP2_LOW + 16'(k), p2[8*k+:8]);
    end
    wr(IDX_INT_ENABLE, 8'h01);
    host.fetch(p2, e1, 1'b0);
    idle;
    chkb(brk, 1'b0);
    rd(IDX_INT_FLAG, 8'h02);
    host.fetch(p1, e1, 1'b0);
    idle;
    chkb(brk, 1'b1);
    chk8(vec, f_vec(1'b0, 1'b1));
    rd(IDX_INT_FLAG, 8'h03);
    wr(IDX_CUR_PC_LOW, ~e1[7:0]);
    for (int k = 0; k < 3; k++) begin
      rd(IDX_CUR_PC_LOW + 16'(k), e1[8*k+:8]);
      rd(IDX_NEXT_PC_LOW + 16'(k), p1[8*k+:8]);
    end
    wr(IDX_INT_FLAG, 8'h00);
    wr(IDX_INT_ENABLE, 8'h82);
    idle;
    chkb(brk, 1'b0);
    kv = 8'($urandom);
    if (kv == STEP_KEY_VALUE)
      kv = 8'h69;
    wr(IDX_STEP_KEY, kv);
    rd(IDX_STEP_KEY, kv);
    sel_v = 4'h0;
    wr(IDX_STEP_KEY, STEP_KEY_VALUE);
    sel_v = 4'h1;
    rd(IDX_STEP_KEY, kv);
    host.fetch(p1 ^ 24'h000100, e1, 1'b1);
    rd(IDX_INT_FLAG, 8'h00);
    wr(IDX_STEP_KEY, 8'h96);
    host.fetch(p1 ^ 24'h000100, e1, 1'b0);
    rd(IDX_INT_FLAG, 8'h00);
    host.fetch(p1 ^ 24'h000100, e1, 1'b1);
    rd(IDX_INT_FLAG, 8'h80);
    chkb(brk, 1'b1);
    host.fetch(p2, e1, 1'b0);
    rd(IDX_INT_FLAG, 8'h82);
    wr(IDX_INT_FLAG, 8'h00);
    wr(IDX_INT_ENABLE, 8'h01);
    host.enter(1'b0);
    idle;
    chkb(irqp | wdte | (|tmr), 1'b0);
    rd(IDX_SUSPEND, 8'h01);
    d = 8'($urandom) | 8'h01;
    wr(IDX_SUSPEND, d);
    rd(IDX_SUSPEND, d & SUSP_BITS_MASK);
    chk8({irqp, wdte, tmr, 3'b000}, d & PERMIT_MASK);
    wr(IDX_SUSPEND, 8'hf8);
    rd(IDX_SUSPEND, 8'hf8);
    chkb(act, 1'b0);
    a = 7'($urandom);
    wr(IDX_DBG_SLV_ADDR, {1'b0, a});
    host.i2c(a);
    idle;
    chkb(dbg, 1'b0);
    wr(IDX_DBG_SLV_ADDR, {1'b1, a});
    host.i2c(a ^ 7'h01);
    host.fetch(p1, e1, 1'b0);
    idle;
    chkb(dbg, 1'b0);
    host.i2c(a);
    idle;
    chkb(dbg, 1'b1);
    chk8(vec, f_vec(1'b1, 1'b1));
    host.enter(1'b1);
    idle;
    chkb(dbg, 1'b0);
    chk8(vec, f_vec(1'b0, 1'b1));
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chkb(wdte & irqp & (&tmr), 1'b1);
    chkb(brk, 1'b0);
    chkb(act, 1'b0);
    rd(IDX_DBG_SLV_ADDR, RST_DBG_ID);
    rd(IDX_INT_FLAG, RST_INT_FLAG);
    rd(IDX_SUSPEND, RST_SUSPEND);
    wr(IDX_SUSPEND, 8'hf8);
    summarize;
  end
endmodule : bp_debug_unit_tb
